// ---- bil_defines.svh ----
`ifndef BIL_DEFINES_SVH
`define BIL_DEFINES_SVH

// register byte offsets
`define BIL_REG_CTRL        8'h00
`define BIL_REG_STATUS      8'h04
`define BIL_REG_IRQ_STATUS  8'h08
`define BIL_REG_IRQ_MASK    8'h0c
`define BIL_REG_WORDS       8'h10
`define BIL_REG_CRC         8'h14
`define BIL_REG_PLL         8'h18
`define BIL_REG_FREQ_CALC   8'h1c

// security register field positions
`define BIL_SEC_SECURE_BOOT 5

// irq status bit positions
`define BIL_IRQ_DONE        0
`define BIL_IRQ_ERROR       1

// image format constants
`define BIL_BYPASS_MARK     32'h0d15ab1e
`define BIL_CRC_POLY        32'hedb88320
`define BIL_CRC_INIT        32'hffffffff

// initial pll settings
`define BIL_PLL_OD_RST      3'h1
`define BIL_PLL_F_RST       12'h03f
`define BIL_PLL_R_RST       6'h00
`define BIL_PLL_RATIO       8'h10

// clock block 0 default reference rate in MHz
`define BIL_REF_CLK_MHZ     8'h64

// internal reset period, ns, and the clock period in ns
`define BIL_CLK_PERIOD_NS   5
`define BIL_RST_MIN_NS      15000
`define BIL_RST_CYCLES      ((`BIL_RST_MIN_NS + `BIL_CLK_PERIOD_NS - 1) / `BIL_CLK_PERIOD_NS)

// ram address width (64k words)
`define BIL_RAM_AW          16

`endif

// ---- bil_pkg.sv ----
package bil_pkg;

  // loader sequence states, one-hot
  typedef enum logic [8:0] {
    BIL_ST_RESET   = 9'h001,
    BIL_ST_WAIT    = 9'h002,
    BIL_ST_SECLOAD = 9'h004,
    BIL_ST_SELECT  = 9'h008,
    BIL_ST_COUNT   = 9'h010,
    BIL_ST_PROG    = 9'h020,
    BIL_ST_CHECK   = 9'h040,
    BIL_ST_RUN     = 9'h080,
    BIL_ST_ERROR   = 9'h100
  } bil_state_e;

  // one byte on the boot stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bil_byte_s;

  // pll divider settings
  typedef struct packed {
    logic [2:0]  od;
    logic [11:0] f;
    logic [5:0]  r;
  } bil_pll_s;

endpackage : bil_pkg

// ---- bil_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bil_defines.svh"

// program ram, registered read port
module bil_ram (
  input  wire logic                     clk_sys_i,
  input  wire logic                     we_i,
  input  wire logic [`BIL_RAM_AW-1:0]   waddr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic [`BIL_RAM_AW-1:0]   raddr_i,
  output logic      [31:0]              rdata_o
);

  logic [31:0] mem [0:(1<<`BIL_RAM_AW)-1];

  // write and registered read
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : bil_ram
`default_nettype wire

// ---- bil_boot_loader.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bil_defines.svh"

// Contract
// - while chip reset pin is low hold reset, pulldown all gpio pins
// - after reset release run internal reset, boot 15 to 150 us later
// - security bit 5 set boots from otp, else from flash
// - flash booting uses the tile 0 quad-spi ports
// - image is word count, count times four bytes, then check word
// - check word 0x0d15ab1e skips crc verification
// - count and check word assembled little-endian, low byte first
// - program written from lowest ram address, started at that address
// - crc covers count bytes and program bytes, not check word
// - reflected crc 0xedb88320, preset all ones, result inverted
// - boot pll ratio 16: output divider 1, multiplier 63, ref divider 0
// - tile freq = osc*(f+1)/2/(r+1)/(od+1)
// - on reset all ports use clock block 0 at 100 mhz
// - security register loaded from otp before boot source chosen
// - secure boot starts at otp address 0, bypassing boot rom
module bil_boot_loader
  import bil_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  input  wire logic                    chip_rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // security word and otp boot stream
  input  wire logic                    otp_sec_valid_i,
  input  wire logic [31:0]             otp_sec_word_i,
  input  wire logic                    otp_byte_valid_i,
  input  wire logic [7:0]              otp_byte_i,
  output logic                         otp_sec_req_o,
  output logic                         otp_stream_en_o,
  output logic      [12:0]             otp_start_addr_o,
  // tile-0 quad-spi flash stream
  input  wire logic                    flash_byte_valid_i,
  input  wire logic [7:0]              flash_byte_i,
  output logic                         flash_stream_en_o,
  // chip-side controls
  output logic                         gpio_pulldown_o,
  output logic                         tile_reset_o,
  output logic                         boot_rom_bypass_o,
  output logic                         ports_on_clkblk0_o,
  output logic      [7:0]              clkblk0_mhz_o,
  output logic      [2:0]              pll_output_divider_o,
  output logic      [11:0]             pll_feedback_mult_o,
  output logic      [5:0]              pll_ref_divider_o,
  output logic                         core_start_o,
  output logic      [`BIL_RAM_AW-1:0]  core_start_addr_o,
  output logic                         boot_done_o,
  output logic                         boot_error_o,
  output logic                         irq_o,
  // program ram read port
  input  wire logic [`BIL_RAM_AW-1:0]  ram_raddr_i,
  output logic      [31:0]             ram_rdata_o
);

  bil_state_e            state_ff, nxt_state;
  logic [1:0]            rst_sync_ff;
  logic [15:0]           rst_cnt_ff;
  logic                  secure_ff;
  logic [31:0]           sec_word_ff;
  logic [31:0]           shift_ff;
  logic [1:0]            bcnt_ff;
  logic [31:0]           words_ff;
  logic [31:0]           wcnt_ff;
  logic [31:0]           crc_ff;
  logic [`BIL_RAM_AW-1:0] waddr_ff;
  logic                  ram_we_ff;
  logic [31:0]           ram_wd_ff;
  logic [1:0]            irq_st_ff;
  logic [1:0]            irq_mask_ff;
  logic                  restart_ff;
  bil_pll_s              pll_ff;
  bil_byte_s             in_b;
  logic [31:0]           word_full;
  logic [31:0]           crc_next;
  logic                  word_done;
  logic                  chk_ok;
  logic [1:0]            irq_set;
  logic [31:0]           freq_calc;

  // synchronise the chip reset pin
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], chip_rst_n_i};
    end
  end

  // byte source by boot selection
  always_comb begin
    if (secure_ff) begin
      in_b.valid = otp_byte_valid_i & (state_ff[4] | state_ff[5] | state_ff[6]);
      in_b.data  = otp_byte_i;
    end else begin
      in_b.valid = flash_byte_valid_i & (state_ff[4] | state_ff[5] | state_ff[6]);
      in_b.data  = flash_byte_i;
    end
  end

  // little-endian word assembly
  assign word_full = {in_b.data, shift_ff[31:8]};
  assign word_done = in_b.valid & (bcnt_ff == 2'h3);

  // bytewise reflected crc step
  always_comb begin
    crc_next = crc_ff ^ {24'h000000, in_b.data};
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ `BIL_CRC_POLY)
                             : (crc_next >> 1);
    end
  end

  // check word resolves: bypass marker or inverted residue match
  assign chk_ok = (word_full == `BIL_BYPASS_MARK) |
                  (word_full == ~crc_ff);

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BIL_ST_RESET:   if (rst_sync_ff[1]) nxt_state = BIL_ST_WAIT;
      BIL_ST_WAIT:    if (rst_cnt_ff == 16'(`BIL_RST_CYCLES - 1))
                        nxt_state = BIL_ST_SECLOAD;
      BIL_ST_SECLOAD: if (otp_sec_valid_i) nxt_state = BIL_ST_SELECT;
      BIL_ST_SELECT:  nxt_state = BIL_ST_COUNT;
      BIL_ST_COUNT:   if (word_done) begin
                        nxt_state = (word_full == 32'h0) ? BIL_ST_CHECK
                                                         : BIL_ST_PROG;
                      end
      BIL_ST_PROG:    if (word_done && wcnt_ff == words_ff - 32'h1)
                        nxt_state = BIL_ST_CHECK;
      BIL_ST_CHECK:   if (word_done) begin
                        nxt_state = chk_ok ? BIL_ST_RUN : BIL_ST_ERROR;
                      end
      BIL_ST_RUN:     if (restart_ff) nxt_state = BIL_ST_WAIT;
      BIL_ST_ERROR:   if (restart_ff) nxt_state = BIL_ST_WAIT;
    endcase
    if (!rst_sync_ff[1]) begin
      nxt_state = BIL_ST_RESET;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_ff <= BIL_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // internal reset period counter
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_ff != BIL_ST_WAIT) begin
      rst_cnt_ff <= 16'h0;
    end else begin
      rst_cnt_ff <= rst_cnt_ff + 16'h1;
    end
  end

  // security word capture and boot source
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sec_word_ff <= 32'h0;
      secure_ff   <= 1'b0;
    end else if (state_ff == BIL_ST_SECLOAD && otp_sec_valid_i) begin
      sec_word_ff <= otp_sec_word_i;
      secure_ff   <= otp_sec_word_i[`BIL_SEC_SECURE_BOOT];
    end
  end

  // byte shifter and byte-in-word count
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_ff == BIL_ST_SELECT) begin
      shift_ff <= 32'h0;
      bcnt_ff  <= 2'h0;
    end else if (in_b.valid) begin
      shift_ff <= word_full;
      bcnt_ff  <= bcnt_ff + 2'h1;
    end
  end

  // crc over count and program bytes only
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_ff == BIL_ST_SELECT) begin
      crc_ff <= `BIL_CRC_INIT;
    end else if (in_b.valid && state_ff != BIL_ST_CHECK) begin
      crc_ff <= crc_next;
    end
  end

  // word count and program word counter
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_ff == BIL_ST_SELECT) begin
      words_ff <= 32'h0;
      wcnt_ff  <= 32'h0;
    end else if (word_done && state_ff == BIL_ST_COUNT) begin
      words_ff <= word_full;
    end else if (word_done && state_ff == BIL_ST_PROG) begin
      wcnt_ff <= wcnt_ff + 32'h1;
    end
  end

  // ram write port from lowest address upward
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state_ff == BIL_ST_SELECT) begin
      waddr_ff  <= '0;
      ram_we_ff <= 1'b0;
      ram_wd_ff <= 32'h0;
    end else begin
      ram_we_ff <= word_done && state_ff == BIL_ST_PROG;
      ram_wd_ff <= word_full;
      if (ram_we_ff) begin
        waddr_ff <= waddr_ff + 16'h1;
      end
    end
  end

  bil_ram u_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (ram_we_ff),
    .waddr_i   (waddr_ff),
    .wdata_i   (ram_wd_ff),
    .raddr_i   (ram_raddr_i),
    .rdata_o   (ram_rdata_o)
  );

  // pll settings, boot values then software writable
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pll_ff.od <= `BIL_PLL_OD_RST;
      pll_ff.f  <= `BIL_PLL_F_RST;
      pll_ff.r  <= `BIL_PLL_R_RST;
    end else if (avs_write_i && avs_address_i == `BIL_REG_PLL) begin
      pll_ff.od <= avs_writedata_i[22:20];
      pll_ff.f  <= avs_writedata_i[17:6];
      pll_ff.r  <= avs_writedata_i[5:0];
    end
  end

  // tile frequency for a 1 MHz oscillator, in units of 1/2 MHz
  assign freq_calc = 32'(({20'h0, pll_ff.f} + 32'h1) /
                         (({26'h0, pll_ff.r} + 32'h1) *
                          ({29'h0, pll_ff.od} + 32'h1)));

  // interrupt events, set wins over write-one clear
  assign irq_set[`BIL_IRQ_DONE]  = state_ff == BIL_ST_CHECK && word_done
                                   && chk_ok;
  assign irq_set[`BIL_IRQ_ERROR] = state_ff == BIL_ST_CHECK && word_done
                                   && !chk_ok;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_st_ff   <= 2'h0;
      irq_mask_ff <= 2'h0;
      restart_ff  <= 1'b0;
    end else begin
      restart_ff <= avs_write_i && avs_address_i == `BIL_REG_CTRL
                    && avs_writedata_i[0];
      if (avs_write_i && avs_address_i == `BIL_REG_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata_i[1:0];
      end
      if (avs_write_i && avs_address_i == `BIL_REG_IRQ_STATUS) begin
        irq_st_ff <= (irq_st_ff & ~avs_writedata_i[1:0]) | irq_set;
      end else begin
        irq_st_ff <= irq_st_ff | irq_set;
      end
    end
  end

  // avalon read data, one cycle wait
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i) begin
      unique case (avs_address_i)
        `BIL_REG_CTRL:       avs_readdata_o <= 32'h0;
        `BIL_REG_STATUS:     avs_readdata_o <= {23'h0, state_ff};
        `BIL_REG_IRQ_STATUS: avs_readdata_o <= {30'h0, irq_st_ff};
        `BIL_REG_IRQ_MASK:   avs_readdata_o <= {30'h0, irq_mask_ff};
        `BIL_REG_WORDS:      avs_readdata_o <= words_ff;
        `BIL_REG_CRC:        avs_readdata_o <= ~crc_ff;
        `BIL_REG_PLL:        avs_readdata_o <= {9'h0, pll_ff.od, 2'h0,
                                                pll_ff.f, pll_ff.r};
        `BIL_REG_FREQ_CALC:  avs_readdata_o <= freq_calc;
        default:             avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // read held one cycle, writes accepted immediately
  logic rd_ack_ff;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rd_ack_ff <= 1'b0;
    end else begin
      rd_ack_ff <= avs_read_i && !rd_ack_ff;
    end
  end
  assign avs_waitrequest_o = avs_read_i && !rd_ack_ff;

  // chip-side outputs
  assign gpio_pulldown_o      = state_ff[0];
  assign tile_reset_o         = state_ff[0] | state_ff[1];
  assign otp_sec_req_o        = state_ff[2];
  assign otp_stream_en_o      = secure_ff & (state_ff[4] | state_ff[5]
                                             | state_ff[6]);
  assign otp_start_addr_o     = 13'h0000;
  assign boot_rom_bypass_o    = secure_ff;
  assign flash_stream_en_o    = !secure_ff & (state_ff[4] | state_ff[5]
                                              | state_ff[6]);
  assign ports_on_clkblk0_o   = 1'b1;
  assign clkblk0_mhz_o        = `BIL_REF_CLK_MHZ;
  assign pll_output_divider_o = pll_ff.od;
  assign pll_feedback_mult_o  = pll_ff.f;
  assign pll_ref_divider_o    = pll_ff.r;
  assign core_start_o         = state_ff == BIL_ST_RUN;
  assign core_start_addr_o    = '0;
  assign boot_done_o          = state_ff == BIL_ST_RUN;
  assign boot_error_o         = state_ff == BIL_ST_ERROR;
  assign irq_o                = |(irq_st_ff & irq_mask_ff);

  logic unused_ok;
  assign unused_ok = ^{sec_word_ff, `BIL_PLL_RATIO};

endmodule : bil_boot_loader
`default_nettype wire

// ---- bil_boot_loader_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bil_defines.svh"

// boot sequencing checks on the loader top ports
module bil_boot_loader_sva (
  input wire logic                   clk_sys_i,
  input wire logic                   resetn_i,
  input wire logic                   chip_rst_n_i,
  input wire logic                   otp_sec_valid_i,
  input wire logic                   otp_sec_req_o,
  input wire logic                   otp_stream_en_o,
  input wire logic                   flash_stream_en_o,
  input wire logic                   otp_byte_valid_i,
  input wire logic                   flash_byte_valid_i,
  input wire logic                   gpio_pulldown_o,
  input wire logic                   tile_reset_o,
  input wire logic                   boot_rom_bypass_o,
  input wire logic [12:0]            otp_start_addr_o,
  input wire logic                   core_start_o,
  input wire logic [`BIL_RAM_AW-1:0] core_start_addr_o,
  input wire logic                   boot_done_o,
  input wire logic                   boot_error_o
);
  logic [14:0] hi_cnt_ff;
  logic        sec_ok_ff;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // cycles since the chip reset pin went high, saturating
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !chip_rst_n_i) hi_cnt_ff <= '0;
    else if (hi_cnt_ff != '1) hi_cnt_ff <= hi_cnt_ff + 15'h1;
  end

  // security word seen since the tile left reset
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || tile_reset_o) sec_ok_ff <= 1'b0;
    else if (otp_sec_req_o && otp_sec_valid_i) sec_ok_ff <= 1'b1;
  end

  pin_hold_a:
    assert property (!chip_rst_n_i [*4] |-> gpio_pulldown_o && tile_reset_o)
    else $error("tile not held while reset pin low");
  int_reset_a:
    assert property ($fell(tile_reset_o) |->
      hi_cnt_ff >= 15'd3000 && hi_cnt_ff <= 15'd30000)
    else $error("internal reset period out of range");
  flash_src_a:
    assert property (flash_stream_en_o |-> !otp_stream_en_o && !boot_rom_bypass_o)
    else $error("flash used while otp selected");
  otp_src_a:
    assert property (otp_stream_en_o |->
      boot_rom_bypass_o && otp_start_addr_o == 13'h0000)
    else $error("otp boot not from address zero");
  sec_first_a:
    assert property ((otp_stream_en_o || flash_stream_en_o) |-> sec_ok_ff)
    else $error("source chosen before security word");
  start_addr_a:
    assert property ($rose(core_start_o) |-> core_start_addr_o == '0 && boot_done_o)
    else $error("program start address wrong");
  no_start_err_a:
    assert property (boot_error_o |-> !core_start_o && !boot_done_o)
    else $error("program started after check failure");
  done_last_a:
    assert property ($rose(boot_done_o || boot_error_o) |->
      $past(flash_stream_en_o && flash_byte_valid_i ||
            otp_stream_en_o && otp_byte_valid_i))
    else $error("completion without final byte");
endmodule : bil_boot_loader_sva

bind bil_boot_loader bil_boot_loader_sva bil_boot_loader_sva_i (.*);
`default_nettype wire

// ---- bil_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// otp and flash byte source, full rate or every other cycle
module bil_src_model
  import bil_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sec_req_i,
  input  wire logic        otp_en_i,
  input  wire logic        flash_en_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] sec_word_i,
  output logic             sec_valid_o,
  output logic      [31:0] sec_word_o,
  output bil_byte_s        otp_o,
  output bil_byte_s        flash_o
);
  logic [7:0] img [64];
  int         n_bytes = 0;
  int         ptr = 0;
  logic       gap = 1'b0;

  // idle lines toggle so stale values never look valid
  initial begin
    sec_valid_o = 1'b0;
    sec_word_o  = 32'h0;
    otp_o       = '0;
    flash_o     = '0;
  end

  // security word answers one cycle after the request
  always @(posedge clk_sys_i) begin
    sec_valid_o <= sec_req_i;
    sec_word_o  <= sec_req_i ? sec_word_i : ~sec_word_o;
  end

  // stream bytes while a source is enabled
  always @(posedge clk_sys_i) begin
    logic v;
    v = (otp_en_i | flash_en_i) && !gap && ptr < n_bytes;
    gap     <= slow_i & ~gap;
    ptr     <= (otp_en_i | flash_en_i) ? ptr + int'(v) : 0;
    otp_o   <= {otp_en_i & v, v ? img[ptr] : ~otp_o.data};
    flash_o <= {flash_en_i & v, v ? img[ptr] : ~flash_o.data};
  end
endmodule : bil_src_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bil_defines.svh"

// loader bench: image boots and register checks
module tb_top;
  import bil_pkg::*;
  logic                   clk_sys_i = 1'b0;
  logic                   resetn_i = 1'b0;
  logic                   chip_rst_n_i = 1'b0;
  logic                   avs_read_i = 1'b0;
  logic                   avs_write_i = 1'b0;
  logic [7:0]             avs_address_i = 8'h00;
  logic [31:0]            avs_writedata_i = 32'h0;
  logic [31:0]            sec_word = 32'h0;
  logic [31:0]            avs_readdata_o, otp_sec_word_i, ram_rdata_o, rd;
  logic [7:0]             otp_byte_i, flash_byte_i, clkblk0_mhz_o;
  logic [12:0]            otp_start_addr_o;
  logic [2:0]             pll_output_divider_o;
  logic [11:0]            pll_feedback_mult_o;
  logic [5:0]             pll_ref_divider_o;
  logic [`BIL_RAM_AW-1:0] core_start_addr_o;
  logic [`BIL_RAM_AW-1:0] ram_raddr_i = '0;
  logic avs_waitrequest_o, otp_sec_valid_i, otp_byte_valid_i;
  logic flash_byte_valid_i, otp_sec_req_o, otp_stream_en_o;
  logic flash_stream_en_o, gpio_pulldown_o, tile_reset_o;
  logic boot_rom_bypass_o, ports_on_clkblk0_o, core_start_o;
  logic boot_done_o, boot_error_o, irq_o, saw_f, saw_o;
  logic                   slow = 1'b0;
  logic [7:0]             img [64];
  bil_byte_s              otp_b, flash_b;
  int                     failures = 0;
  int                     n_compared = 0;

  bil_boot_loader bil_boot_loader_i (.*);
  bil_src_model bil_src_model_i (.clk_sys_i, .sec_req_i(otp_sec_req_o),
    .otp_en_i(otp_stream_en_o), .flash_en_i(flash_stream_en_o),
    .slow_i(slow), .sec_word_i(sec_word), .sec_valid_o(otp_sec_valid_i),
    .sec_word_o(otp_sec_word_i), .otp_o(otp_b), .flash_o(flash_b));
  assign {otp_byte_valid_i, otp_byte_i} = otp_b;
  assign {flash_byte_valid_i, flash_byte_i} = flash_b;

  // 200 mhz clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  // note which source the loader asked for, cleared while the tile is held
  always @(posedge clk_sys_i) begin
    if (tile_reset_o === 1'b1) begin
      saw_f <= 1'b0;
      saw_o <= 1'b0;
    end else begin
      if (flash_stream_en_o === 1'b1) saw_f <= 1'b1;
      if (otp_stream_en_o === 1'b1) saw_o <= 1'b1;
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic avm(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_read_i      <= !w;
    avs_write_i     <= w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (avs_waitrequest_o !== 1'b0) begin
      failures++;
      $display("wrong value at %0t: bus wait timeout", $time);
    end
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : avm

  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c ^= {24'h0, img[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction : crc_of

  // image kinds: 0 bypass mark, 1 good crc, 2 bad crc
  task automatic load(input int w, input int k);
    logic [31:0] cw;
    for (int i = 0; i < 4; i++) img[i] = 8'(w >> (8 * i));
    for (int i = 4; i < 4 * w + 4; i++) img[i] = 8'(i * 37 + 5);
    cw = (k == 0) ? 32'h0d15ab1e : crc_of(4 * w + 4) ^ 32'(k == 2);
    for (int i = 0; i < 4; i++) img[4 * w + 4 + i] = cw[8 * i +: 8];
    bil_src_model_i.img = img;
    bil_src_model_i.n_bytes = 4 * w + 8;
  endtask : load

  // hard pulses the bench reset as well, otherwise only the reset pin
  task automatic boot(input logic [31:0] sec, input logic hard);
    int n = 0;
    sec_word     <= sec;
    resetn_i     <= !hard;
    chip_rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk({gpio_pulldown_o, tile_reset_o}, 2'b11, "held");
    chk({pll_output_divider_o, pll_feedback_mult_o, pll_ref_divider_o},
        {3'h1, 12'h03f, 6'h00}, "pll boot");
    chk({ports_on_clkblk0_o, clkblk0_mhz_o}, 9'h164, "clk blk");
    chip_rst_n_i <= 1'b1;
    while (boot_done_o !== 1'b1 && boot_error_o !== 1'b1 && n < 9000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(32'(n >= 3000 && n < 9000), 32'h1, "boot delay");
  endtask : boot

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    print_verdict();
  end

  // flash bypass, crc good, crc bad, then otp secure boot by the pin alone
  initial begin
    load(2, 0);
    boot(32'h0, 1'b1);
    chk({core_start_o, core_start_addr_o}, 17'h10000, "start");
    chk({saw_f, saw_o, boot_rom_bypass_o}, 3'b100, "flash");
    repeat (2) @(posedge clk_sys_i);
    chk(ram_rdata_o, {img[7], img[6], img[5], img[4]}, "ram 0");
    ram_raddr_i <= 16'h1;
    repeat (2) @(posedge clk_sys_i);
    chk(ram_rdata_o, {img[11], img[10], img[9], img[8]}, "ram 1");
    avm(1'b0, `BIL_REG_WORDS, 32'h0);
    chk(rd, 32'h2, "words");
    avm(1'b0, `BIL_REG_STATUS, 32'h0);
    chk(rd, 32'(BIL_ST_RUN), "state");
    avm(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
    avm(1'b1, `BIL_REG_IRQ_MASK, 32'h0);
    chk(irq_o, 1'b0, "irq masked");
    avm(1'b1, `BIL_REG_IRQ_MASK, 32'h3);
    chk(irq_o, 1'b1, "irq done");
    avm(1'b1, `BIL_REG_IRQ_STATUS, 32'h1);
    chk(irq_o, 1'b0, "irq clear");
    avm(1'b1, `BIL_REG_PLL, {9'h0, 3'h1, 2'h0, 12'h07f, 6'h01});
    chk({pll_output_divider_o, pll_feedback_mult_o, pll_ref_divider_o},
        {3'h1, 12'h07f, 6'h01}, "pll set");
    avm(1'b0, `BIL_REG_PLL, 32'h0);
    chk(rd, {9'h0, 3'h1, 2'h0, 12'h07f, 6'h01}, "pll read");
    avm(1'b0, `BIL_REG_FREQ_CALC, 32'h0);
    chk(rd, 32'd32, "freq");
    avm(1'b1, `BIL_REG_CTRL, 32'h1);
    avm(1'b0, `BIL_REG_STATUS, 32'h0);
    chk(rd, 32'(BIL_ST_WAIT), "restart");
    load(3, 1);
    slow <= 1'b1;
    boot(32'h0, 1'b1);
    chk(boot_done_o, 1'b1, "crc ok");
    avm(1'b0, `BIL_REG_CRC, 32'h0);
    chk(rd, crc_of(16), "crc");
    load(1, 2);
    boot(32'h0, 1'b1);
    chk({boot_error_o, core_start_o}, 2'b10, "crc bad");
    avm(1'b0, `BIL_REG_IRQ_STATUS, 32'h0);
    chk(rd[1], 1'b1, "err irq");
    load(0, 1);
    slow <= 1'b0;
    boot(32'h20, 1'b0);
    chk({saw_f, saw_o, boot_rom_bypass_o, otp_start_addr_o},
        16'h6000, "otp");
    chk(boot_done_o, 1'b1, "otp done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
